/* design/supply_fault_map.vh */
// Purpose: Bit positions, reset values and timing figures for the supply fault monitor
// Assumes: 20 MHz system clock
// Notes:   Definitions only
`ifndef SUPPLY_FAULT_MAP_VH
`define SUPPLY_FAULT_MAP_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS          50
`define RAIL_DEGLITCH_NS       25000
`define XCVR_REG_OV_DGL_NS     250000
`define PRIMARY_REF_BLANK_NS   10000000
`define THERM_REF_BLANK_NS     2000000

// ----------------------------------------------------------------
// Rail fault register fields
// ----------------------------------------------------------------
`define RAIL_ANALOG_OV_BIT     0
`define RAIL_ANALOG_UV_RST_BIT 1
`define RAIL_XCVR_REG_OV_BIT   2
`define RAIL_DIGITAL_OV_BIT    3
`define RAIL_THERM_OV_BIT      4
`define RAIL_THERM_UV_BIT      5
`define RAIL_XCVR_SUP_UV_BIT   6

// ----------------------------------------------------------------
// System fault register one
// ----------------------------------------------------------------
`define SYS1_ALWAYS_ON_OV_BIT  0

// ----------------------------------------------------------------
// System fault register two
// ----------------------------------------------------------------
`define SYS2_ANALOG_OSC_BIT    0
`define SYS2_DIG_GND_OPEN_BIT  1
`define SYS2_THERM_OSC_BIT     2
`define SYS2_XCVR_GND_OPEN_BIT 3
`define SYS2_PRIMARY_OSC_BIT   4

// ----------------------------------------------------------------
// System fault register three
// ----------------------------------------------------------------
`define SYS3_INPUT_SUP_UV_BIT  0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FAULT_REG_RESET        8'h00

`endif

/* design/rail_deglitch.v */
// Purpose: Assertion deglitch for one comparator output
// Assumes: Input already synchronised to clk
// Notes:   Output rises after CYCLES consecutive high samples, falls at once
`timescale 1ns/1ps
`default_nettype none

module rail_deglitch #(
    parameter integer CYCLES = 500
) (
    input  wire clk,
    input  wire rst_n,
    input  wire level_in,
    output reg  level_out
);

    reg [17:0] count;

    // Only assertion is filtered: a fault that goes away must not hold off reset release
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            count     <= 18'h00000;
            level_out <= 1'b0;
        end
        else if (!level_in)
        begin
            count     <= 18'h00000;
            level_out <= 1'b0;
        end
        else if (count >= CYCLES[17:0] - 18'h00001)
        begin
            level_out <= 1'b1;
        end
        else
        begin
            count <= count + 18'h00001;
        end
    end

endmodule
`default_nettype wire

/* design/blank_timer.v */
// Purpose: One-shot blanking window after a start pulse
// Assumes: Start is a one-cycle pulse on clk
// Notes:   A new start restarts the window
`timescale 1ns/1ps
`default_nettype none

module blank_timer #(
    parameter integer CYCLES = 200000
) (
    input  wire clk,
    input  wire rst_n,
    input  wire start,
    output wire busy
);

    reg [17:0] remaining;

    assign busy = (remaining != 18'h00000);

    always @(posedge clk)
    begin
        if (!rst_n)
            remaining <= 18'h00000;
        else if (start)
            remaining <= CYCLES[17:0];
        else if (busy)
            remaining <= remaining - 18'h00001;
    end

endmodule
`default_nettype wire

/* design/supply_fault_monitor_startup.v */
// Purpose: Supervises supply rails, references and ground pins, raises sticky
//          fault flags and requests digital reset or power-on reset
// Assumes: Comparator outputs arrive asynchronously; mode and clear inputs are on clk
// Notes:   Flags clear by one-cycle write-one strobes; a set in the same cycle wins
//
// How it works
// [R1] Analog rail overvoltage sets rail fault flag
// [R2] Analog undervoltage resets digital; flag after restart
// [R3] Analog rail oscillation sets system fault two
// [R4] Transceiver regulator overvoltage sets rail fault flag
// [R5] Digital rail overvoltage sets rail fault flag
// [R6] Digital supply low holds digital logic reset
// [R7] Open digital ground sets system fault two
// [R8] Host enables thermistor reference, waits before measuring
// [R9] Thermistor reference over/undervoltage set rail flags
// [R10] Thermistor reference oscillation sets system fault two
// [R11] Always-on rail overvoltage sets system fault one
// [R12] Always-on rail undervoltage forces power-on reset
// [R13] Transceiver supply undervoltage sets rail fault flag
// [R14] Open transceiver ground sets system fault two
// [R15] Input supply undervoltage sets system fault three
// [R16] System keeps input supply steady in shutdown
// [R17] Host clears ECC test, enables addressing, assigns addresses
// [R18] Host writes base, stack and top roles
// [R19] Host dummy-reads then clears link faults
// [R20] Host waits for full wake before mode commands
// [R21] Primary reference oscillation flag, blanked 10ms after active
// [R22] Primary reference only active; protector sleep and active
// [R23] Flags stay set until host clears them
// [R24] Every comparator is deglitched before acting
`timescale 1ns/1ps
`default_nettype none
`include "supply_fault_map.vh"

module supply_fault_monitor_startup #(
    parameter integer XCVR_REG_OV_DGL_CYCLES = `XCVR_REG_OV_DGL_NS / `CLK_PERIOD_NS,
    parameter integer PRIMARY_REF_BLANK_CYCLES = `PRIMARY_REF_BLANK_NS / `CLK_PERIOD_NS,
    parameter integer THERM_REF_BLANK_CYCLES = `THERM_REF_BLANK_NS / `CLK_PERIOD_NS
) (
    input  wire       clk,
    input  wire       rst_n,
    // Raw comparator and detector outputs from the analog side
    input  wire       analog_rail_ov_cmp,
    input  wire       analog_rail_uv_cmp,
    input  wire       analog_rail_osc_det,
    input  wire       xcvr_regulator_ov_cmp,
    input  wire       digital_rail_ov_cmp,
    input  wire       digital_rail_reset_cmp,
    input  wire       digital_ground_open_det,
    input  wire       thermistor_ref_ov_cmp,
    input  wire       thermistor_ref_uv_cmp,
    input  wire       thermistor_ref_osc_det,
    input  wire       always_on_rail_ov_cmp,
    input  wire       always_on_rail_uv_cmp,
    input  wire       xcvr_supply_uv_cmp,
    input  wire       xcvr_ground_open_det,
    input  wire       input_supply_uv_cmp,
    input  wire       primary_ref_osc_det,
    // Mode and control from the device's own logic
    input  wire       active_mode,
    input  wire       sleep_mode,
    input  wire       thermistor_ref_enable,
    // Write-one-to-clear strobes per fault register
    input  wire [7:0] rail_fault_clear,
    input  wire [7:0] system_fault_one_clear,
    input  wire [7:0] system_fault_two_clear,
    input  wire [7:0] system_fault_three_clear,
    // Fault registers
    output reg  [7:0] rail_fault_reg,
    output reg  [7:0] system_fault_reg_one,
    output reg  [7:0] system_fault_reg_two,
    output reg  [7:0] system_fault_reg_three,
    // Resets and reference enables
    output reg        digital_reset_hold,
    output reg        power_on_reset_req,
    output reg        primary_ref_on,
    output reg        protector_ref_on,
    output reg        thermistor_ref_on
);

    // ----------------------------------------------------------------
    // Channel numbering
    // ----------------------------------------------------------------
    localparam integer NUM_CH        = 16;
    localparam integer CH_AN_OV      = 0;
    localparam integer CH_AN_UV      = 1;
    localparam integer CH_AN_OSC     = 2;
    localparam integer CH_XREG_OV    = 3;
    localparam integer CH_DIG_OV     = 4;
    localparam integer CH_DIG_RST    = 5;
    localparam integer CH_DIG_GND    = 6;
    localparam integer CH_TH_OV      = 7;
    localparam integer CH_TH_UV      = 8;
    localparam integer CH_TH_OSC     = 9;
    localparam integer CH_AO_OV      = 10;
    localparam integer CH_AO_UV      = 11;
    localparam integer CH_XSUP_UV    = 12;
    localparam integer CH_XGND       = 13;
    localparam integer CH_IN_UV      = 14;
    localparam integer CH_PR_OSC     = 15;
    localparam integer DGL_CYCLES    = `RAIL_DEGLITCH_NS / `CLK_PERIOD_NS;

    wire [NUM_CH-1:0] raw_in;
    reg  [NUM_CH-1:0] sync_a;
    reg  [NUM_CH-1:0] sync_b;
    wire [NUM_CH-1:0] filtered;

    assign raw_in = {primary_ref_osc_det,
                     input_supply_uv_cmp,
                     xcvr_ground_open_det,
                     xcvr_supply_uv_cmp,
                     always_on_rail_uv_cmp,
                     always_on_rail_ov_cmp,
                     thermistor_ref_osc_det,
                     thermistor_ref_uv_cmp,
                     thermistor_ref_ov_cmp,
                     digital_ground_open_det,
                     digital_rail_reset_cmp,
                     digital_rail_ov_cmp,
                     xcvr_regulator_ov_cmp,
                     analog_rail_osc_det,
                     analog_rail_uv_cmp,
                     analog_rail_ov_cmp};

    // ----------------------------------------------------------------
    // Synchronise and deglitch every comparator
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync_a <= 16'h0000;
            sync_b <= 16'h0000;
        end
        else
        begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1)
        begin : g_dgl
            // The transceiver regulator comparator is slower by design, hence its own count
            rail_deglitch #(
                .CYCLES    ((ch == CH_XREG_OV) ? XCVR_REG_OV_DGL_CYCLES : DGL_CYCLES)
            ) u_dgl (
                .clk       (clk),
                .rst_n     (rst_n),
                .level_in  (sync_b[ch]),
                .level_out (filtered[ch])
            ); // [R24]
        end
    endgenerate

    // ----------------------------------------------------------------
    // Reference enables and blanking windows
    // ----------------------------------------------------------------
    reg  active_d;
    // Thermistor blanking starts when the reference really turns on, whichever of enable and active came last
    wire primary_blank;
    wire therm_blank;
    wire active_rise;
    wire therm_rise;

    assign active_rise = active_mode & ~active_d;
    assign therm_rise  = thermistor_ref_enable & active_mode & ~thermistor_ref_on;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            active_d          <= 1'b0;
            primary_ref_on    <= 1'b0;
            protector_ref_on  <= 1'b0;
            thermistor_ref_on <= 1'b0;
        end
        else
        begin
            active_d          <= active_mode;
            primary_ref_on    <= active_mode; // [R22]
            protector_ref_on  <= active_mode | sleep_mode; // [R22]
            // The thermistor reference is derived from the primary one, so it needs active mode
            thermistor_ref_on <= thermistor_ref_enable & active_mode;
        end
    end

    blank_timer #(
        .CYCLES (PRIMARY_REF_BLANK_CYCLES)
    ) u_primary_blank (
        .clk    (clk),
        .rst_n  (rst_n),
        .start  (active_rise),
        .busy   (primary_blank)
    ); // [R21]

    // Startup blanking keeps the charging thermistor reference from tripping its limits
    blank_timer #(
        .CYCLES (THERM_REF_BLANK_CYCLES)
    ) u_therm_blank (
        .clk    (clk),
        .rst_n  (rst_n),
        .start  (therm_rise),
        .busy   (therm_blank)
    );

    wire therm_watch;
    wire primary_watch;

    // Limit checks wait out the charge-up of the external capacitor
    assign therm_watch   = thermistor_ref_on & ~therm_blank;
    // The timer only counts from the edge after the rise, so the rising cycle is masked here
    assign primary_watch = active_mode & ~primary_blank & ~active_rise; // [R21]

    // ----------------------------------------------------------------
    // Reset requests
    // ----------------------------------------------------------------
    reg analog_uv_seen;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            digital_reset_hold <= 1'b0;
            power_on_reset_req <= 1'b0;
            analog_uv_seen     <= 1'b0;
        end
        else
        begin
            digital_reset_hold <= filtered[CH_AN_UV] | filtered[CH_DIG_RST]; // [R2] [R6]
            power_on_reset_req <= filtered[CH_AO_UV]; // [R12]
            analog_uv_seen     <= filtered[CH_AN_UV];
        end
    end

    // The cause is recorded on release, the first cycle the digital logic is running again
    wire analog_uv_restart;

    assign analog_uv_restart = analog_uv_seen & ~filtered[CH_AN_UV]; // [R2]

    // ----------------------------------------------------------------
    // Set vectors per register
    // ----------------------------------------------------------------
    reg [7:0] rail_set;
    reg [7:0] sys1_set;
    reg [7:0] sys2_set;
    reg [7:0] sys3_set;

    always @*
    begin
        rail_set = 8'h00;
        sys1_set = 8'h00;
        sys2_set = 8'h00;
        sys3_set = 8'h00;
        rail_set[`RAIL_ANALOG_OV_BIT]     = filtered[CH_AN_OV]; // [R1]
        rail_set[`RAIL_ANALOG_UV_RST_BIT] = analog_uv_restart; // [R2]
        rail_set[`RAIL_XCVR_REG_OV_BIT]   = filtered[CH_XREG_OV]; // [R4]
        rail_set[`RAIL_DIGITAL_OV_BIT]    = filtered[CH_DIG_OV]; // [R5]
        rail_set[`RAIL_THERM_OV_BIT]      = filtered[CH_TH_OV] & therm_watch; // [R9]
        rail_set[`RAIL_THERM_UV_BIT]      = filtered[CH_TH_UV] & therm_watch; // [R9]
        rail_set[`RAIL_XCVR_SUP_UV_BIT]   = filtered[CH_XSUP_UV]; // [R13]
        sys1_set[`SYS1_ALWAYS_ON_OV_BIT]  = filtered[CH_AO_OV]; // [R11]
        sys2_set[`SYS2_ANALOG_OSC_BIT]    = filtered[CH_AN_OSC]; // [R3]
        sys2_set[`SYS2_DIG_GND_OPEN_BIT]  = filtered[CH_DIG_GND]; // [R7]
        sys2_set[`SYS2_THERM_OSC_BIT]     = filtered[CH_TH_OSC] & thermistor_ref_on; // [R10]
        sys2_set[`SYS2_XCVR_GND_OPEN_BIT] = filtered[CH_XGND]; // [R14]
        sys2_set[`SYS2_PRIMARY_OSC_BIT]   = filtered[CH_PR_OSC] & primary_watch; // [R21]
        sys3_set[`SYS3_INPUT_SUP_UV_BIT]  = filtered[CH_IN_UV]; // [R15]
    end

    // ----------------------------------------------------------------
    // Sticky fault registers
    // ----------------------------------------------------------------
    // Set beats clear so an event in the clearing cycle survives
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            rail_fault_reg         <= `FAULT_REG_RESET;
            system_fault_reg_one   <= `FAULT_REG_RESET;
            system_fault_reg_two   <= `FAULT_REG_RESET;
            system_fault_reg_three <= `FAULT_REG_RESET;
        end
        else
        begin
            rail_fault_reg         <= (rail_fault_reg & ~rail_fault_clear) | rail_set; // [R23]
            system_fault_reg_one   <= (system_fault_reg_one & ~system_fault_one_clear) | sys1_set; // [R23]
            system_fault_reg_two   <= (system_fault_reg_two & ~system_fault_two_clear) | sys2_set; // [R23]
            system_fault_reg_three <= (system_fault_reg_three & ~system_fault_three_clear) | sys3_set; // [R23]
        end
    end

endmodule
`default_nettype wire

/* verif/analog_side_model.sv */
// Purpose: Stand-in for the analog comparators and detectors feeding the monitor
// Assumes: Bench states which fault conditions are present
// Notes:   Levels move on the falling edge, so they arrive out of step with clk
`timescale 1ns/1ps
`default_nettype none
module analog_side_model (
    input  wire logic        clk,
    input  wire logic [15:0] fault_want,
    output var  logic [15:0] cmp_level
);
    // Only requested conditions move a line; input supply stays steady otherwise
    initial cmp_level = 16'h0000;
    always @(negedge clk)
    begin
        cmp_level <= fault_want;
    end
endmodule
`default_nettype wire

/* verif/supply_fault_checker_asserts.sv */
// Purpose: Port-level checks on the supply fault monitor
// Assumes: Single clock domain, synchronous active-low reset
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module supply_fault_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       analog_rail_ov_cmp,
    input wire logic       digital_rail_ov_cmp,
    input wire logic       digital_rail_reset_cmp,
    input wire logic       digital_ground_open_det,
    input wire logic       always_on_rail_uv_cmp,
    input wire logic       active_mode,
    input wire logic       sleep_mode,
    input wire logic [7:0] rail_fault_clear,
    input wire logic [7:0] rail_fault_reg,
    input wire logic [7:0] system_fault_reg_two,
    input wire logic       digital_reset_hold,
    input wire logic       power_on_reset_req,
    input wire logic       primary_ref_on,
    input wire logic       protector_ref_on,
    input wire logic       thermistor_ref_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Saturating count of consecutive high samples; a plain repeat would be too long
    logic [9:0] hold_cnt;
    always_ff @(posedge clk)
    begin
        if (!rst_n || !digital_rail_reset_cmp) hold_cnt <= 10'h000;
        else if (hold_cnt != 10'h3FF) hold_cnt <= hold_cnt + 10'h001;
    end
    sequence quiet_dig_ov;
        (!digital_rail_ov_cmp)[*5];
    endsequence
    sequence therm_off;
        (!thermistor_ref_on)[*2];
    endsequence
    a_flag_sticky: assert property (rail_fault_reg[0] && !rail_fault_clear[0] |=> rail_fault_reg[0])
        else $error("analog overvoltage flag dropped without clear");
    a_clear_takes: assert property (quiet_dig_ov ##0 rail_fault_clear[3] |=> !rail_fault_reg[3])
        else $error("digital overvoltage flag survived clear");
    a_ov_deglitched: assert property ($rose(rail_fault_reg[0]) |-> $past(analog_rail_ov_cmp, 8))
        else $error("analog overvoltage flag set without filtered cause");
    a_gnd_deglitched: assert property ($rose(system_fault_reg_two[1]) |-> $past(digital_ground_open_det, 8))
        else $error("ground open flag set without filtered cause");
    a_hold_follows: assert property (hold_cnt >= 10'h1FE |-> digital_reset_hold)
        else $error("digital reset not held on low digital supply");
    a_por_release: assert property ((!always_on_rail_uv_cmp)[*6] |-> !power_on_reset_req)
        else $error("power-on reset held without cause");
    a_primary_mode: assert property (active_mode ##1 active_mode |-> primary_ref_on)
        else $error("primary reference off in active mode");
    a_primary_idle: assert property (!active_mode ##1 !active_mode |-> !primary_ref_on)
        else $error("primary reference on outside active mode");
    a_protector_on: assert property ((active_mode || sleep_mode) |=> protector_ref_on)
        else $error("protector reference off in sleep or active");
    a_therm_gate: assert property (therm_off ##0 !rail_fault_reg[4] |=> !rail_fault_reg[4])
        else $error("thermistor overvoltage flag set with reference off");
endmodule
bind supply_fault_monitor_startup supply_fault_checker supply_fault_checker_i (
    .clk(clk), .rst_n(rst_n), .analog_rail_ov_cmp(analog_rail_ov_cmp), .digital_rail_ov_cmp(digital_rail_ov_cmp),
    .digital_rail_reset_cmp(digital_rail_reset_cmp), .digital_ground_open_det(digital_ground_open_det),
    .always_on_rail_uv_cmp(always_on_rail_uv_cmp), .active_mode(active_mode), .sleep_mode(sleep_mode),
    .rail_fault_clear(rail_fault_clear), .rail_fault_reg(rail_fault_reg), .system_fault_reg_two(system_fault_reg_two),
    .digital_reset_hold(digital_reset_hold), .power_on_reset_req(power_on_reset_req),
    .primary_ref_on(primary_ref_on), .protector_ref_on(protector_ref_on), .thermistor_ref_on(thermistor_ref_on));
`default_nettype wire

/* verif/supply_fault_monitor_startup_tb.sv */
// Purpose: Self-checking bench for the supply fault monitor
// Assumes: Shortened blanking and regulator deglitch parameters
// Notes:   Comparator lines come through the analog side model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED %0t value differs", $time); end end
module supply_fault_monitor_startup_tb;
    logic        clk;
    logic        rst_n;
    logic        active_mode;
    logic        sleep_mode;
    logic        therm_en;
    logic [15:0] want;
    logic [15:0] lvl;
    logic [31:0] clr;
    logic [31:0] flags;
    logic        hold;
    logic        por;
    logic        pri_on;
    logic        prot_on;
    logic        therm_on;
    logic [33:0] probe;
    int          mismatches = 0;
    int          cmp_count = 0;
    assign probe = {por, hold, flags};
    analog_side_model analog_side_model_i (.clk(clk), .fault_want(want), .cmp_level(lvl));
    supply_fault_monitor_startup #(.XCVR_REG_OV_DGL_CYCLES(20), .PRIMARY_REF_BLANK_CYCLES(50),
        .THERM_REF_BLANK_CYCLES(30)) supply_fault_monitor_startup_i (
        .clk(clk), .rst_n(rst_n), .analog_rail_ov_cmp(lvl[0]), .analog_rail_uv_cmp(lvl[1]),
        .analog_rail_osc_det(lvl[2]), .xcvr_regulator_ov_cmp(lvl[3]), .digital_rail_ov_cmp(lvl[4]),
        .digital_rail_reset_cmp(lvl[5]), .digital_ground_open_det(lvl[6]), .thermistor_ref_ov_cmp(lvl[7]),
        .thermistor_ref_uv_cmp(lvl[8]), .thermistor_ref_osc_det(lvl[9]), .always_on_rail_ov_cmp(lvl[10]),
        .always_on_rail_uv_cmp(lvl[11]), .xcvr_supply_uv_cmp(lvl[12]), .xcvr_ground_open_det(lvl[13]),
        .input_supply_uv_cmp(lvl[14]), .primary_ref_osc_det(lvl[15]), .active_mode(active_mode),
        .sleep_mode(sleep_mode), .thermistor_ref_enable(therm_en), .rail_fault_clear(clr[7:0]),
        .system_fault_one_clear(clr[15:8]), .system_fault_two_clear(clr[23:16]),
        .system_fault_three_clear(clr[31:24]), .rail_fault_reg(flags[7:0]), .system_fault_reg_one(flags[15:8]),
        .system_fault_reg_two(flags[23:16]), .system_fault_reg_three(flags[31:24]), .digital_reset_hold(hold),
        .power_on_reset_req(por), .primary_ref_on(pri_on), .protector_ref_on(prot_on), .thermistor_ref_on(therm_on));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic complete_run();
        if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait for one probe bit; running out ends the run
    task automatic wait_hi(input int b, output int n);
        n = 0;
        while (probe[b] !== 1'b1)
        begin
            cyc(1);
            n++;
            if (n > 800)
            begin
                mismatches++;
                $display("CHECK FAILED %0t wait ran out", $time);
                complete_run();
            end
        end
    endtask
    task automatic set_cmp(input int ci, input logic v);
        @(posedge clk);
        want[ci] <= v;
    endtask
    task automatic t_reset_vals();
        `CHK(flags, 32'h0000_0000)
        `CHK({hold, por, pri_on, prot_on, therm_on}, 5'h00)
    endtask
    // A pulse well short of the filter length must leave no trace
    task automatic t_glitch();
        set_cmp(0, 1'b1);
        cyc(100);
        set_cmp(0, 1'b0);
        cyc(600);
        `CHK(flags[0], 1'b0)
    endtask
    // Reference must be enabled and the device active before these can flag
    task automatic t_gating();
        set_cmp(7, 1'b1);
        set_cmp(15, 1'b1);
        cyc(600);
        `CHK(flags[4], 1'b0)
        `CHK(flags[20], 1'b0)
        // Oscillation already filtered high as active starts: the blanking window must hide it
        @(posedge clk);
        active_mode <= 1'b1;
        cyc(20);
        `CHK(flags[20], 1'b0)
        @(posedge clk);
        active_mode <= 1'b0;
        set_cmp(7, 1'b0);
        set_cmp(15, 1'b0);
        cyc(5);
    endtask
    task automatic t_refs();
        @(posedge clk);
        sleep_mode <= 1'b1;
        cyc(3);
        `CHK({pri_on, prot_on}, 2'h1)
        @(posedge clk);
        sleep_mode <= 1'b0;
        active_mode <= 1'b1;
        therm_en <= 1'b1;
        cyc(3);
        `CHK({pri_on, prot_on, therm_on}, 3'h7)
    endtask
    task automatic t_flags();
        int ci[13] = '{0, 2, 3, 4, 6, 10, 12, 13, 14, 7, 8, 9, 15};
        int fi[13] = '{0, 16, 2, 3, 17, 8, 6, 19, 24, 4, 5, 18, 20};
        int n;
        int ex;
        for (int k = 0; k < 13; k++)
        begin
            ex = (ci[k] == 3) ? 23 : 503;
            set_cmp(ci[k], 1'b1);
            wait_hi(fi[k], n);
            `CHK((n >= ex - 4) && (n <= ex + 4), 1'b1)
            set_cmp(ci[k], 1'b0);
            cyc(10);
            `CHK(flags[fi[k]], 1'b1)
            @(posedge clk);
            clr[fi[k]] <= 1'b1;
            @(posedge clk);
            clr <= 32'h0000_0000;
            cyc(1);
            `CHK(flags, 32'h0000_0000)
        end
    endtask
    task automatic t_resets();
        int n;
        set_cmp(1, 1'b1);
        wait_hi(32, n);
        `CHK(flags[1], 1'b0)
        set_cmp(1, 1'b0);
        cyc(8);
        `CHK({hold, flags[1]}, 2'h1)
        set_cmp(5, 1'b1);
        wait_hi(32, n);
        `CHK(n > 490, 1'b1)
        cyc(8);
        set_cmp(5, 1'b0);
        set_cmp(11, 1'b1);
        wait_hi(33, n);
        `CHK(n > 490, 1'b1)
        set_cmp(11, 1'b0);
        cyc(8);
        `CHK({hold, por}, 2'h0)
    endtask
    initial
    begin
        rst_n = 1'b0;
        active_mode = 1'b0;
        sleep_mode = 1'b0;
        therm_en = 1'b0;
        want = 16'h0000;
        clr = 32'h0000_0000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Chain addressing and role setup travel over the host link, not these ports
        cyc(3);
        t_reset_vals();
        t_glitch();
        t_gating();
        t_refs();
        t_flags();
        t_resets();
        complete_run();
    end
endmodule
`default_nettype wire
